/* hdl/rpbch_handler.sv */
`timescale 1ns/100ps
// Notes on behaviour
// - Operation accepts only on and off; on after reset
// - Off-then-on restart clears alarms and shutdowns
// - Clear faults only from side in control
// - Clear faults works whatever the write lock
// - Persisting fault sets its status bit again
// - Write lock: all, only itself, itself plus operation
// - Write lock setting is always writable
// - Factory restore reloads all; factory set fixed
// - Single factory restore reloads one register
// - User save and reload act on one register
// - Data format reads linear code and exponent
// - Input turn-on and turn-off levels read-only
// - Fan setup supports only duty-cycle mode
// - Fan override only raises duty; zero releases
// - Output overvoltage latches output off; action read-only
// - Output voltage warnings assert fault notify
// - Output undervoltage fault ignored during input loss
// - Other fault actions read-only; overcurrent reports f8, the rest report restart
// - Overtemp action only latched or hiccup, default hiccup
// - Hottest sensor compared with fault and warn
// - Input overvoltage fault level may only drop
// - Input undervoltage warn level may only rise
// - Bad data value sets communication status bit six
module rpbch_handler
  import rpbch_pkg::*;
#(
  parameter logic [4:0] VOUT_EXP = 5'h00
) (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire rpbch_req_t  req,
  input  wire rpbch_tele_t tele,
  output logic             rsp_valid,
  output logic [15:0]      rsp_data,
  output logic             output_on,
  output logic             fault_notify_n,
  output logic [7:0]       fan_duty
);

  // ==========================================================
  // Decode
  logic [15:0]     cur_val [NREG];
  logic [NREG-1:0] data_ok;
  logic            hit;
  logic [IDXW-1:0] hit_idx;
  logic            sel_hit;
  logic [IDXW-1:0] sel_idx;
  logic            wr;
  logic            rd;
  logic            wr_allowed;
  logic            clr_ok;
  logic            restart;
  logic            bad_cmd;
  logic            bad_data;
  logic            oper_ok;
  logic            op_on_reg;
  logic            latch_off_reg;
  logic [7:0]      wlock;
  rpbch_stat_t     cond;
  rpbch_stat_t     stat_reg;
  logic [7:0]      comm_reg;
  logic [15:0]     hot;

  assign wr    = req.valid & req.write;
  assign rd    = req.valid & ~req.write;
  assign wlock = cur_val[IX_WLOCK][7:0];
  assign wr_allowed = (req.code == CMD_WLOCK) || (wlock == WLOCK_ALL) ||
                      ((wlock == WLOCK_OPER) && (req.code == CMD_OPER));
  assign clr_ok  = wr && (req.code == CMD_CLEAR) && req.in_control;
  assign oper_ok = wr && wr_allowed && (req.code == CMD_OPER) &&
                   ((req.data[7:0] == OPER_ON) || (req.data[7:0] == OPER_OFF));
  assign restart = oper_ok && (req.data[7:0] == OPER_ON) && !op_on_reg;

  always_comb begin
    hit     = 1'b0;
    hit_idx = '0;
    sel_hit = 1'b0;
    sel_idx = '0;
    for (int k = 0; k < NREG; k++) begin
      if (req.code == REG_CODE[k]) begin
        hit     = 1'b1;
        hit_idx = IDXW'(k);
      end
      if (req.data[7:0] == REG_CODE[k]) begin
        sel_hit = 1'b1;
        sel_idx = IDXW'(k);
      end
    end
  end

  function automatic logic value_ok(input int idx, input logic [15:0] d,
                                    input logic [15:0] cur);
    case (idx)
      IX_WLOCK: value_ok = (d[15:8] == 8'h00) && ((d[7:0] == WLOCK_ALL) ||
                           (d[7:0] == WLOCK_ONLY) || (d[7:0] == WLOCK_OPER));
      IX_FCFG:  value_ok = (d == FAN_CFG_DUTY);
      IX_FAN:   value_ok = (d <= FAN_MAX_PCT);
      IX_OTACT: value_ok = (d == OT_LATCHED) || (d == OT_HICCUP);
      IX_VIOVF: value_ok = (d <= cur);
      IX_VIUVW: value_ok = (d >= cur);
      default:  value_ok = 1'b1;
    endcase
  endfunction : value_ok

  always_comb begin
    bad_cmd  = 1'b0;
    bad_data = 1'b0;
    if (wr) begin
      case (req.code)
        CMD_CLEAR:     bad_cmd = 1'b0;
        CMD_OPER:      bad_data = wr_allowed && !oper_ok;
        CMD_FACT_ALL:  bad_data = 1'b0;
        CMD_FACT_ONE,
        CMD_USER_SAVE,
        CMD_USER_LOAD: bad_data = wr_allowed && !sel_hit;
        default: begin
          if (hit) begin
            bad_data = wr_allowed && !data_ok[hit_idx];
          end else begin
            bad_cmd = 1'b1;
          end
        end
      endcase
    end else if (rd) begin
      case (req.code)
        CMD_OPER, CMD_DATA_FMT, CMD_VIN_ON, CMD_VIN_OFF, CMD_VOOV_ACT,
        CMD_VOUV_ACT, CMD_IOC_ACT, CMD_VIOV_ACT, CMD_VIUV_ACT,
        CMD_SUMMARY, CMD_COMM_STAT: bad_cmd = 1'b0;
        default: bad_cmd = !hit;
      endcase
    end
  end

  // ==========================================================
  // Operating and user register sets
  for (genvar i = 0; i < NREG; i++) begin : g_reg
    logic [15:0] val_reg;
    logic [15:0] usr_reg;
    assign cur_val[i] = val_reg;
    assign data_ok[i] = value_ok(i, req.data, val_reg);

    always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
        val_reg <= FACTORY[i];
      end else if (wr && wr_allowed) begin
        if (req.code == CMD_FACT_ALL) begin
          val_reg <= FACTORY[i];
        end else if (req.code == CMD_FACT_ONE && sel_hit && sel_idx == IDXW'(i)) begin
          val_reg <= FACTORY[i];
        end else if (req.code == CMD_USER_LOAD && sel_hit && sel_idx == IDXW'(i)) begin
          val_reg <= usr_reg;
        end else if (hit && hit_idx == IDXW'(i) && data_ok[i]) begin
          val_reg <= req.data;
        end
      end
    end

    always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
        usr_reg <= FACTORY[i];
      end else if (wr && wr_allowed && req.code == CMD_USER_SAVE && sel_hit &&
                   sel_idx == IDXW'(i)) begin
        usr_reg <= val_reg;
      end
    end
  end

  // ==========================================================
  // Operation state
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      op_on_reg <= 1'b1;
    end else if (oper_ok) begin
      op_on_reg <= (req.data[7:0] == OPER_ON);
    end
  end

  // ==========================================================
  // Fault monitors
  assign hot = (tele.temp_a > tele.temp_b) ? tele.temp_a : tele.temp_b;

  always_comb begin
    cond.vout_ov_f = tele.vout > cur_val[IX_VOOVF];
    cond.vout_ov_w = tele.vout > cur_val[IX_VOOVW];
    cond.vout_uv_w = output_on && (tele.vout < cur_val[IX_VOUVW]);
    cond.vout_uv_f = output_on && !tele.input_loss &&
                     (tele.vout < cur_val[IX_VOUVF]);
    cond.iout_oc_f = tele.iout > cur_val[IX_IOCF];
    cond.iout_oc_w = tele.iout > cur_val[IX_IOCW];
    cond.vin_ov_f  = tele.vin > cur_val[IX_VIOVF];
    cond.vin_ov_w  = tele.vin > cur_val[IX_VIOVW];
    cond.vin_uv_w  = tele.vin < cur_val[IX_VIUVW];
    cond.vin_uv_f  = tele.vin < cur_val[IX_VIUVF];
    cond.ot_f      = hot > cur_val[IX_OTF];
    cond.ot_w      = hot > cur_val[IX_OTW];
  end

  // Sticky flags; a live condition wins over the clear
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      stat_reg <= '0;
    end else if (clr_ok || restart) begin
      stat_reg <= cond;
    end else begin
      stat_reg <= stat_reg | cond;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      comm_reg <= '0;
    end else begin
      comm_reg[COMM_BAD_CMD]  <= bad_cmd  | (comm_reg[COMM_BAD_CMD]  & ~(clr_ok | restart));
      comm_reg[COMM_BAD_DATA] <= bad_data | (comm_reg[COMM_BAD_DATA] & ~(clr_ok | restart));
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      latch_off_reg <= 1'b0;
    end else if (cond.vout_ov_f || (cond.ot_f && cur_val[IX_OTACT] == OT_LATCHED)) begin
      latch_off_reg <= 1'b1;
    end else if (restart) begin
      // Live latched fault wins over the restart
      latch_off_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Outputs
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      output_on <= 1'b1;
    end else begin
      output_on <= op_on_reg && !latch_off_reg && !cond.vout_ov_f &&
                   !cond.vout_uv_f && !cond.iout_oc_f && !cond.vin_ov_f && !cond.vin_uv_f &&
                   !(cond.ot_f && cur_val[IX_OTACT] == OT_HICCUP);
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      fault_notify_n <= 1'b1;
    end else begin
      fault_notify_n <= !((|stat_reg) || (|comm_reg));
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      fan_duty <= '0;
    end else if (cur_val[IX_FAN][7:0] > tele.fan_need) begin
      fan_duty <= cur_val[IX_FAN][7:0];
    end else begin
      fan_duty <= tele.fan_need;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rsp_valid <= 1'b0;
      rsp_data  <= '0;
    end else begin
      rsp_valid <= rd;
      if (rd) begin
        case (req.code)
          CMD_OPER:      rsp_data <= {8'h00, op_on_reg ? OPER_ON : OPER_OFF};
          CMD_DATA_FMT:  rsp_data <= {8'h00, FMT_LINEAR, VOUT_EXP};
          CMD_VIN_ON:    rsp_data <= VIN_ON_LEVEL;
          CMD_VIN_OFF:   rsp_data <= VIN_OFF_LEVEL;
          CMD_VOOV_ACT:  rsp_data <= {8'h00, ACT_LATCHED};
          CMD_VOUV_ACT,
          CMD_VIOV_ACT,
          CMD_VIUV_ACT:  rsp_data <= {8'h00, ACT_RESTART};
          CMD_IOC_ACT:   rsp_data <= {8'h00, ACT_IOC};
          CMD_SUMMARY:   rsp_data <= {8'h00, 1'b0, !output_on, stat_reg.vout_ov_f,
                                      stat_reg.iout_oc_f, stat_reg.vin_uv_f,
                                      stat_reg.ot_f | stat_reg.ot_w, |comm_reg,
                                      stat_reg.vout_ov_w | stat_reg.vout_uv_w |
                                      stat_reg.vout_uv_f | stat_reg.iout_oc_w |
                                      stat_reg.vin_ov_f | stat_reg.vin_ov_w |
                                      stat_reg.vin_uv_w};
          CMD_COMM_STAT: rsp_data <= {8'h00, comm_reg};
          default:       rsp_data <= hit ? cur_val[hit_idx] : READ_ERR_DATA;
        endcase
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  chk_oper_bad_value: assert property (wr && req.code == CMD_OPER && wr_allowed &&
      req.data[7:0] != OPER_ON && req.data[7:0] != OPER_OFF
      |=> op_on_reg == $past(op_on_reg) && comm_reg[COMM_BAD_DATA])
    else $error("bad operation value was taken");

  chk_restart_unlatch: assert property (restart && !cond.vout_ov_f &&
      !(cond.ot_f && cur_val[IX_OTACT] == OT_LATCHED) |=> !latch_off_reg)
    else $error("restart left the output latched off");

  chk_clear_foreign: assert property (wr && req.code == CMD_CLEAR &&
      !req.in_control |=> (stat_reg & $past(stat_reg)) == $past(stat_reg))
    else $error("clear from side not in control took effect");

  chk_clear_reload: assert property (clr_ok |=> stat_reg == $past(cond))
    else $error("status after clear differs from live faults");

  chk_lock_blocks: assert property (wr && wlock != WLOCK_ALL &&
      req.code == REG_CODE[IX_VOOVW] |=> cur_val[IX_VOOVW] == $past(cur_val[IX_VOOVW]))
    else $error("locked write changed a register");

  chk_lock_always: assert property (wr && req.code == CMD_WLOCK &&
      data_ok[IX_WLOCK] |=> cur_val[IX_WLOCK] == $past(req.data))
    else $error("write lock setting not accepted");

  chk_viov_lower: assert property (wr && wr_allowed &&
      req.code == REG_CODE[IX_VIOVF] && req.data > cur_val[IX_VIOVF]
      |=> $stable(cur_val[IX_VIOVF]) && comm_reg[COMM_BAD_DATA])
    else $error("input overvoltage level was raised");

  chk_viuw_raise: assert property (wr && wr_allowed &&
      req.code == REG_CODE[IX_VIUVW] && req.data < cur_val[IX_VIUVW]
      |=> $stable(cur_val[IX_VIUVW]))
    else $error("input undervoltage warn level was lowered");

  chk_ot_action: assert property (cur_val[IX_OTACT] == OT_LATCHED ||
      cur_val[IX_OTACT] == OT_HICCUP)
    else $error("overtemperature action holds an illegal code");

  chk_fan_floor: assert property (rstn |=> fan_duty >= $past(tele.fan_need))
    else $error("fan duty below internal need");

  chk_ovp_latch: assert property (cond.vout_ov_f
      |=> latch_off_reg ##1 !output_on)
    else $error("output overvoltage did not shut output off");

  cov_restart: cover property (oper_ok && req.data[7:0] == OPER_OFF ##[1:60] restart);
  cov_clear:   cover property (clr_ok ##1 fault_notify_n);
  cov_save:    cover property (wr && req.code == CMD_USER_SAVE ##[1:10]
                               wr && req.code == CMD_USER_LOAD);

endmodule : rpbch_handler

/* hdl/rpbch_pkg.sv */
package rpbch_pkg;

  // ==========================================================
  // Command codes
  localparam logic [7:0] CMD_OPER      = 8'h01;
  localparam logic [7:0] CMD_CLEAR     = 8'h03;
  localparam logic [7:0] CMD_WLOCK     = 8'h10;
  localparam logic [7:0] CMD_FACT_ALL  = 8'h12;
  localparam logic [7:0] CMD_FACT_ONE  = 8'h14;
  localparam logic [7:0] CMD_USER_SAVE = 8'h17;
  localparam logic [7:0] CMD_USER_LOAD = 8'h18;
  localparam logic [7:0] CMD_DATA_FMT  = 8'h20;
  localparam logic [7:0] CMD_VIN_ON    = 8'h35;
  localparam logic [7:0] CMD_VIN_OFF   = 8'h36;
  localparam logic [7:0] CMD_VOOV_ACT  = 8'h41;
  localparam logic [7:0] CMD_VOUV_ACT  = 8'h45;
  localparam logic [7:0] CMD_IOC_ACT   = 8'h47;
  localparam logic [7:0] CMD_VIOV_ACT  = 8'h56;
  localparam logic [7:0] CMD_VIUV_ACT  = 8'h5a;
  localparam logic [7:0] CMD_SUMMARY   = 8'h78;
  localparam logic [7:0] CMD_COMM_STAT = 8'h7e;

  // ==========================================================
  // Data values
  localparam logic [7:0]  OPER_ON       = 8'h80;
  localparam logic [7:0]  OPER_OFF      = 8'h00;
  localparam logic [7:0]  WLOCK_ALL     = 8'h00;
  localparam logic [7:0]  WLOCK_ONLY    = 8'h80;
  localparam logic [7:0]  WLOCK_OPER    = 8'h40;
  localparam logic [15:0] OT_LATCHED    = 16'h0080;
  localparam logic [15:0] OT_HICCUP     = 16'h00c0;
  localparam logic [15:0] FAN_CFG_DUTY  = 16'h0090;
  localparam logic [15:0] FAN_MAX_PCT   = 16'h0064;
  localparam logic [7:0]  ACT_LATCHED   = 8'h80;
  localparam logic [7:0]  ACT_RESTART   = 8'hc0;
  localparam logic [7:0]  ACT_IOC       = 8'hf8;
  localparam logic [2:0]  FMT_LINEAR    = 3'h0;
  localparam logic [15:0] VIN_ON_LEVEL  = 16'h01ae;
  localparam logic [15:0] VIN_OFF_LEVEL = 16'h017c;
  localparam logic [15:0] READ_ERR_DATA = 16'hffff;
  localparam int          COMM_BAD_CMD  = 7;
  localparam int          COMM_BAD_DATA = 6;

  // ==========================================================
  // Writable register table
  localparam int NREG = 16;
  localparam int IDXW = 4;
  localparam int IX_WLOCK = 0;
  localparam int IX_FCFG  = 1;
  localparam int IX_FAN   = 2;
  localparam int IX_VOOVF = 3;
  localparam int IX_VOOVW = 4;
  localparam int IX_VOUVW = 5;
  localparam int IX_VOUVF = 6;
  localparam int IX_IOCF  = 7;
  localparam int IX_IOCW  = 8;
  localparam int IX_OTF   = 9;
  localparam int IX_OTACT = 10;
  localparam int IX_OTW   = 11;
  localparam int IX_VIOVF = 12;
  localparam int IX_VIOVW = 13;
  localparam int IX_VIUVW = 14;
  localparam int IX_VIUVF = 15;
  localparam logic [7:0] REG_CODE [NREG] = '{8'h10, 8'h3a, 8'h3b, 8'h40, 8'h42, 8'h43,
    8'h44, 8'h46, 8'h4a, 8'h4f, 8'h50, 8'h51, 8'h55, 8'h57, 8'h58, 8'h59};
  // Factory set, levels in tenths of a unit
  localparam logic [15:0] FACTORY [NREG] = '{16'h0000, 16'h0090, 16'h0000, 16'h008c,
    16'h0087, 16'h006c, 16'h0064, 16'h0294, 16'h026c, 16'h0514, 16'h00c0, 16'h04b0,
    16'h02f8, 16'h02e4, 16'h0190, 16'h017c};

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        in_control;
    logic [7:0]  code;
    logic [15:0] data;
  } rpbch_req_t;

  typedef struct packed {
    logic [15:0] vout;
    logic [15:0] iout;
    logic [15:0] vin;
    logic [15:0] temp_a;
    logic [15:0] temp_b;
    logic        input_loss;
    logic [7:0]  fan_need;
  } rpbch_tele_t;

  typedef struct packed {
    logic vout_ov_f;
    logic vout_ov_w;
    logic vout_uv_w;
    logic vout_uv_f;
    logic iout_oc_f;
    logic iout_oc_w;
    logic vin_ov_f;
    logic vin_ov_w;
    logic vin_uv_w;
    logic vin_uv_f;
    logic ot_f;
    logic ot_w;
  } rpbch_stat_t;

endpackage : rpbch_pkg

/* tb/rpbch_host_model.sv */
`timescale 1ns/100ps
// ==========================================================
// Host controller on the far side of the register port
module rpbch_host_model
  import rpbch_pkg::*;
#(
  parameter int HOLD_OFF = 50
) (
  input  wire logic        clock,
  output rpbch_req_t       req,
  input  wire logic        rsp_valid,
  input  wire logic [15:0] rsp_data
);
  initial req = '0;

  // One-cycle request, stale data scrambled once released
  task automatic send(input logic w, input logic ctl, input logic [7:0] code,
                      input logic [15:0] data);
    @(posedge clock);
    req <= '{valid: 1'b1, write: w, in_control: ctl, code: code, data: data};
    @(posedge clock);
    req.valid <= 1'b0;
    req.data  <= ~data;
  endtask : send

  // Answer stands from the taking edge until the next edge
  task automatic read(input logic [7:0] code, output logic [15:0] data);
    send(1'b0, 1'b1, code, 16'h0000);
    #1;
    data = (rsp_valid === 1'b1) ? rsp_data : 16'hxxxx;
  endtask : read

  // Off, hold, then on again
  task automatic restart();
    send(1'b1, 1'b1, CMD_OPER, {8'h00, OPER_OFF});
    repeat (HOLD_OFF) @(posedge clock);
    send(1'b1, 1'b1, CMD_OPER, {8'h00, OPER_ON});
  endtask : restart
endmodule : rpbch_host_model

/* tb/tb_top.sv */
`timescale 1ns/100ps
module tb_top
  import rpbch_pkg::*;
;
  localparam logic [4:0]  EXP = 5'h1d;
  localparam logic [15:0] NV  = 16'h0078;
  localparam logic [15:0] NT  = 16'h0300;
  logic        clock = 1'b0;
  logic        rstn  = 1'b0;
  rpbch_req_t  req;
  rpbch_tele_t tele;
  logic        rsp_valid;
  logic [15:0] rsp_data;
  logic        output_on;
  logic        fault_notify_n;
  logic [7:0]  fan_duty;
  logic [15:0] got;
  int          miscompares = 0;
  int          cmp_count   = 0;
  int          cycles      = 0;
  logic [7:0]  ro_code [8] = '{CMD_DATA_FMT, CMD_VIN_ON, CMD_VIN_OFF, CMD_VOOV_ACT,
                               CMD_VOUV_ACT, CMD_IOC_ACT, CMD_VIOV_ACT, CMD_VIUV_ACT};
  logic [15:0] ro_val [8]  = '{{8'h00, 3'h0, EXP}, 16'h01ae, 16'h017c, 16'h0080,
                               16'h00c0, 16'h00f8, 16'h00c0, 16'h00c0};

  always #20 clock = ~clock;

  rpbch_handler #(.VOUT_EXP(EXP)) rpbch_handler_i (
    .clock(clock), .rstn(rstn), .req(req), .tele(tele), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .output_on(output_on), .fault_notify_n(fault_notify_n),
    .fan_duty(fan_duty));

  rpbch_host_model #(.HOLD_OFF(50)) rpbch_host_model_i (
    .clock(clock), .req(req), .rsp_valid(rsp_valid), .rsp_data(rsp_data));

  // ==========================================================
  // Helpers
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    rpbch_host_model_i.send(1'b1, 1'b1, code, data);
  endtask : wr

  task automatic rd(input logic [7:0] code, input logic [15:0] exp,
                    input logic [15:0] mask = 16'hffff);
    rpbch_host_model_i.read(code, got);
    check($sformatf("reg %h", code), exp, got & mask);
  endtask : rd

  task automatic pins(input logic on);
    repeat (2) @(posedge clock);
    #1;
    check("output_on", {15'h0000, on}, {15'h0000, output_on});
  endtask : pins

  task automatic nf(input logic exp);
    check("fault_notify_n", {15'h0000, exp}, {15'h0000, fault_notify_n});
  endtask : nf

  task automatic tel(input logic [15:0] v, input logic [15:0] ta, input logic [15:0] tb,
                     input logic loss);
    @(posedge clock);
    tele.vout       <= v;
    tele.temp_a     <= ta;
    tele.temp_b     <= tb;
    tele.input_loss <= loss;
  endtask : tel

  task automatic fan(input logic [7:0] need, input logic [7:0] exp);
    @(posedge clock);
    tele.fan_need <= need;
    repeat (2) @(posedge clock);
    #1;
    check("fan_duty", {8'h00, exp}, {8'h00, fan_duty});
  endtask : fan

  task automatic wrap_up();
    $display("Compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      miscompares++;
      wrap_up();
    end
  end

  // ==========================================================
  // Sequence
  initial begin
    tele = '{vout: NV, iout: 16'h0100, vin: 16'h01e0, temp_a: NT, temp_b: NT,
             input_loss: 1'b0, fan_need: 8'h10};
    @(posedge clock);
    #1;
    check("output_on", 16'h0001, {15'h0000, output_on});
    @(posedge clock);
    rstn <= 1'b1;
    rd(CMD_WLOCK, 16'h0000);
    rd(8'h50, 16'h00c0);
    rd(8'h3a, 16'h0090);
    for (int i = 0; i < 8; i++) begin
      rd(ro_code[i], ro_val[i]);
      wr(ro_code[i], 16'h0011);
      rd(ro_code[i], ro_val[i]);
    end
    rd(CMD_COMM_STAT, 16'h0080, 16'h00c0);
    wr(CMD_CLEAR, 16'h0000);
    // On/off codes and restart
    wr(CMD_OPER, 16'h0000);
    pins(1'b0);
    wr(CMD_OPER, 16'h0055);
    pins(1'b0);
    rd(CMD_COMM_STAT, 16'h0040, 16'h00c0);
    tel(16'h008d, NT, NT, 1'b0);
    rpbch_host_model_i.restart();
    pins(1'b0);
    tel(NV, NT, NT, 1'b0);
    wr(CMD_CLEAR, 16'h0000);
    pins(1'b0);
    rpbch_host_model_i.restart();
    pins(1'b1);
    nf(1'b1);
    rd(CMD_COMM_STAT, 16'h0000, 16'h00c0);
    // Warnings, clear ignored from side not in control, persisting warning
    tel(16'h0088, NT, NT, 1'b0);
    pins(1'b1);
    nf(1'b0);
    tel(NV, NT, NT, 1'b0);
    rpbch_host_model_i.send(1'b1, 1'b0, CMD_CLEAR, 16'h0000);
    pins(1'b1);
    nf(1'b0);
    wr(CMD_CLEAR, 16'h0000);
    pins(1'b1);
    nf(1'b1);
    tel(16'h006a, NT, NT, 1'b0);
    wr(CMD_CLEAR, 16'h0000);
    pins(1'b1);
    nf(1'b0);
    tel(16'h0050, NT, NT, 1'b1);
    pins(1'b1);
    tel(NV, NT, NT, 1'b0);
    wr(CMD_CLEAR, 16'h0000);
    // Write lock
    wr(CMD_WLOCK, 16'h0080);
    wr(8'h42, 16'h0080);
    rd(8'h42, 16'h0087);
    wr(CMD_OPER, 16'h0000);
    pins(1'b1);
    rd(CMD_WLOCK, 16'h0080);
    tel(16'h0088, NT, NT, 1'b0);
    tel(NV, NT, NT, 1'b0);
    wr(CMD_CLEAR, 16'h0000);
    pins(1'b1);
    nf(1'b1);
    wr(CMD_WLOCK, 16'h0040);
    wr(CMD_OPER, 16'h0000);
    pins(1'b0);
    wr(8'h42, 16'h0080);
    rd(8'h42, 16'h0087);
    rpbch_host_model_i.restart();
    pins(1'b1);
    wr(CMD_WLOCK, 16'h0011);
    rd(CMD_WLOCK, 16'h0040);
    rd(CMD_COMM_STAT, 16'h0040, 16'h00c0);
    wr(CMD_WLOCK, 16'h0000);
    wr(8'h42, 16'h0080);
    rd(8'h42, 16'h0080);
    // Factory and user defaults
    wr(CMD_FACT_ALL, 16'h0000);
    rd(8'h42, 16'h0087);
    wr(8'h42, 16'h0080);
    wr(8'h43, 16'h0070);
    wr(CMD_FACT_ONE, 16'h0043);
    rd(8'h43, 16'h006c);
    rd(8'h42, 16'h0080);
    wr(8'h46, 16'h0200);
    wr(CMD_USER_SAVE, 16'h0046);
    wr(8'h46, 16'h0210);
    wr(8'h4a, 16'h01f0);
    wr(CMD_USER_LOAD, 16'h0046);
    rd(8'h46, 16'h0200);
    rd(8'h4a, 16'h01f0);
    wr(CMD_FACT_ALL, 16'h0000);
    // Fan
    wr(8'h3a, 16'h0010);
    rd(8'h3a, 16'h0090);
    wr(8'h3b, 16'h0032);
    fan(8'h10, 8'h32);
    fan(8'h40, 8'h40);
    wr(8'h3b, 16'h0000);
    fan(8'h10, 8'h10);
    wr(CMD_CLEAR, 16'h0000);
    wr(8'h3b, 16'h0065);
    rd(8'h3b, 16'h0000);
    rd(CMD_COMM_STAT, 16'h0040, 16'h00c0);
    // Over-temperature action and hottest sensor
    tel(NV, 16'h0520, NT, 1'b0);
    pins(1'b0);
    tel(NV, NT, NT, 1'b0);
    pins(1'b1);
    wr(CMD_CLEAR, 16'h0000);
    wr(8'h50, 16'h0040);
    rd(8'h50, 16'h00c0);
    wr(8'h50, 16'h0080);
    rd(8'h50, 16'h0080);
    tel(NV, 16'h04c0, NT, 1'b0);
    rd(CMD_SUMMARY, 16'h0004, 16'h0004);
    tel(NV, NT, 16'h0520, 1'b0);
    pins(1'b0);
    tel(NV, NT, NT, 1'b0);
    wr(CMD_CLEAR, 16'h0000);
    pins(1'b0);
    rpbch_host_model_i.restart();
    pins(1'b1);
    // One-way limits
    wr(8'h55, 16'h0300);
    rd(8'h55, 16'h02f8);
    wr(8'h55, 16'h02f0);
    rd(8'h55, 16'h02f0);
    wr(8'h58, 16'h0180);
    rd(8'h58, 16'h0190);
    wr(8'h58, 16'h0198);
    rd(8'h58, 16'h0198);
    wrap_up();
  end
endmodule : tb_top
